// *** hw/dsp_add_and_branch_decoder.sv ***
// Decoder for the add, logical-AND, product-accumulate and branch instructions.
//
// Notes on behaviour
// [RQ1] Selector: pin low, test set, test clear, none.
// [RQ2] Flag field bits: zero, negative, overflow, carry.
// [RQ3] Low nibble is mask, bits 4-7 state.
// [RQ4] Condition met when masked comparison leaves any bit.
// [RQ5] Magnitude of accumulator: one word, one cycle.
// [RQ6] Shifted, high and short-immediate sum_without_sign_extend: one cycle.
// [RQ7] Long-immediate shifted add: two words, two cycles.
// [RQ8] Carry, unsigned-low and temp-shifted memory sum_without_sign_extend.
// [RQ9] Short constant added to auxiliary register.
// [RQ10] AND forms: memory, shifted immediate, shift 16.
// [RQ11] Product register added to accumulator, one cycle.
// [RQ12] Jump to accumulator target: one word, four cycles.
// [RQ13] Loop on aux nonzero: four taken, two not.
// [RQ14] Conditional jump: top nibble 1110, selector bits 8-9.
// [RQ15] Pin-low jump: four taken, three not.
// [RQ16] Accumulator sign jumps use fixed flag bytes.
// [RQ17] Carry and overflow jumps: four taken, two not.
// [RQ18] Second word is operand, never a new opcode.
`default_nettype none

module dsp_add_and_branch_decoder
  import dsp_decode_pkg::*;
#(
  parameter int W = dsp_decode_pkg::WORD_W
) (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic [W-1:0]             word_data,
  input  wire logic                     word_valid,
  output logic                          word_ready,
  input  wire logic [3:0]               flags,
  input  wire logic                     test_flag,
  input  wire logic                     branch_input_pin,
  input  wire logic                     aux_reg_nonzero,
  output logic                          dec_valid,
  output dsp_decode_pkg::op_t           dec_op,
  output logic [3:0]                    dec_shift_count,
  output logic [7:0]                    dec_short_field,
  output logic [W-1:0]                  dec_long_word,
  output logic [1:0]                    dec_cond_select,
  output logic [1:0]                    dec_words,
  output logic [2:0]                    dec_cycles,
  output logic                          dec_jump_taken
);

  import dsp_decode_pkg::*;

  function automatic op_t decode_op(input logic [15:0] w);
    op_t op;
    op = OP_UNKNOWN;
    if (w == OPC_MAGNITUDE) op = OP_MAGNITUDE_OF_ACCUMULATOR;          // see [RQ5]
    else if (w == OPC_ACC_PRODUCT) op = OP_ACCUMULATE_PRODUCT;         // see [RQ11]
    else if (w == OPC_JUMP_ACC) op = OP_JUMP_TO_ACCUMULATOR_TARGET;    // see [RQ12]
    else if (w == OPC_AND_HIGH) op = OP_AND_HIGH_IMM;                  // see [RQ10]
    else if (w[15:4] == OPC_ADD_LONG) op = OP_SUM_LONG_IMM;            // see [RQ7]
    else if (w[15:4] == OPC_AND_LONG) op = OP_AND_LONG_IMM;            // see [RQ10]
    else if (w[15:12] == NIB_ADD_SHIFT) op = OP_SUM_SHIFTED;           // see [RQ6]
    else if (w[15:12] == NIB_COND_JUMP) op = OP_CONDITIONAL_JUMP;      // see [RQ14]
    else begin
      unique case (w[15:8])
        PFX_ADD_HIGH:  op = OP_SUM_HIGH;                               // see [RQ6]
        PFX_ADD_SHORT: op = OP_SUM_SHORT_IMM;                          // see [RQ6]
        PFX_SUM_WITH_CARRY:      op = OP_SUM_WITH_CARRY;                         // see [RQ8]
        PFX_SUM_WITHOUT_SIGN_EXTEND:      op = OP_SUM_WITHOUT_SIGN_EXTEND;                // see [RQ8]
        PFX_SUM_SHIFTED_BY_TEMP:      op = OP_SUM_SHIFTED_BY_TEMP;                    // see [RQ8]
        PFX_AUX_INC:   op = OP_AUX_REG_SHORT_INCREMENT;                // see [RQ9]
        PFX_AND_MEM:   op = OP_AND_MEM;                                // see [RQ10]
        PFX_LOOP_AUX:  op = OP_LOOP_ON_AUX_NONZERO;                    // see [RQ13]
        default:       op = OP_UNKNOWN;
      endcase
    end
    return op;
  endfunction : decode_op

  function automatic logic two_words(input op_t op);
    return (op == OP_SUM_LONG_IMM) || (op == OP_AND_LONG_IMM) ||
           (op == OP_AND_HIGH_IMM) || (op == OP_LOOP_ON_AUX_NONZERO) ||
           (op == OP_CONDITIONAL_JUMP);  // see [RQ18]
  endfunction : two_words

  // Cycles for one-word operations; two-word ones are worked out with the operand.
  function automatic logic [2:0] one_word_cycles(input op_t op);
    return (op == OP_JUMP_TO_ACCUMULATOR_TARGET) ? CYC_FOUR : CYC_ONE;  // see [RQ12]
  endfunction : one_word_cycles

  dec_state_t     state_reg;
  logic [2:0]     stall_reg;
  logic [15:0]    opcode_reg;
  op_t            pend_op_reg;
  logic           accept;
  logic           cond_met;
  op_t            first_op;
  logic           emit;
  op_t            emit_op;
  logic [15:0]    emit_word;
  logic [1:0]     emit_words;
  logic [2:0]     emit_cycles;
  logic           emit_taken;
  logic [2:0]     stall_next;

  // The decoder stalls its source for the cycles an instruction takes beyond its word count.
  assign word_ready = (state_reg != ST_STALL);
  assign accept     = word_valid & word_ready;
  assign first_op   = decode_op(word_data[15:0]);

  flag_condition_eval u_cond (
    .cond_source_select (opcode_reg[SEL_LSB +: 2]),
    .flag_state         (opcode_reg[STATE_LSB +: 4]),
    .flag_mask          (opcode_reg[MASK_LSB +: 4]),
    .flags              (flags),
    .test_flag          (test_flag),
    .branch_input_pin   (branch_input_pin),
    .cond_met           (cond_met)
  );

  always_comb begin
    emit        = 1'b0;
    emit_op     = OP_UNKNOWN;
    emit_word   = word_data[15:0];
    emit_words  = WORDS_ONE;
    emit_cycles = CYC_ONE;
    emit_taken  = 1'b0;
    stall_next  = 3'h0;
    if (accept && state_reg == ST_OPCODE && !two_words(first_op)) begin
      emit        = 1'b1;
      emit_op     = first_op;
      emit_cycles = one_word_cycles(first_op);
      emit_taken  = (first_op == OP_JUMP_TO_ACCUMULATOR_TARGET);  // see [RQ12]
      stall_next  = emit_cycles - CYC_ONE;
    end else if (accept && state_reg == ST_OPERAND) begin
      // The operand word is never decoded; the held opcode supplies the fields.
      emit       = 1'b1;  // see [RQ18]
      emit_op    = pend_op_reg;
      emit_word  = opcode_reg;
      emit_words = WORDS_TWO;
      unique case (pend_op_reg)
        OP_LOOP_ON_AUX_NONZERO: begin
          emit_taken  = aux_reg_nonzero;
          emit_cycles = aux_reg_nonzero ? CYC_FOUR : CYC_TWO;  // see [RQ13]
        end
        OP_CONDITIONAL_JUMP: begin
          emit_taken = cond_met;  // see [RQ14] see [RQ16] see [RQ17]
          if (cond_met) emit_cycles = CYC_FOUR;
          else if (opcode_reg[SEL_LSB +: 2] == SRC_PIN_LOW) emit_cycles = CYC_THREE;  // see [RQ15]
          else emit_cycles = CYC_TWO;  // see [RQ17]
        end
        default: emit_cycles = CYC_TWO;  // see [RQ7] see [RQ10]
      endcase
      stall_next = emit_cycles - CYC_TWO;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_OPCODE;
      stall_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_OPCODE: begin
          if (accept && two_words(first_op)) begin
            state_reg <= ST_OPERAND;  // see [RQ18]
          end else if (emit && stall_next != 3'h0) begin
            state_reg <= ST_STALL;
            stall_reg <= stall_next;
          end
        end
        ST_OPERAND: begin
          if (emit && stall_next != 3'h0) begin
            state_reg <= ST_STALL;
            stall_reg <= stall_next;
          end else if (emit) begin
            state_reg <= ST_OPCODE;
          end
        end
        ST_STALL: begin
          stall_reg <= stall_reg - 3'h1;
          if (stall_reg == 3'h1) state_reg <= ST_OPCODE;
        end
        default: state_reg <= ST_OPCODE;
      endcase
    end
  end

  // The first word is held so that its fields survive the operand fetch.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcode_reg  <= 16'h0000;
      pend_op_reg <= OP_UNKNOWN;
    end else if (accept && state_reg == ST_OPCODE) begin
      opcode_reg  <= word_data[15:0];
      pend_op_reg <= first_op;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec_valid       <= 1'b0;
      dec_op          <= OP_UNKNOWN;
      dec_shift_count <= 4'h0;
      dec_short_field <= 8'h00;
      dec_long_word   <= '0;
      dec_cond_select <= 2'h0;
      dec_words       <= 2'h0;
      dec_cycles      <= 3'h0;
      dec_jump_taken  <= 1'b0;
    end else begin
      dec_valid <= emit;
      if (emit) begin
        dec_op          <= emit_op;
        dec_shift_count <= (emit_op == OP_SUM_LONG_IMM || emit_op == OP_AND_LONG_IMM) ?
                           emit_word[3:0] : emit_word[SHIFT_LSB +: 4];  // see [RQ6] see [RQ7]
        dec_short_field <= emit_word[7:0];  // see [RQ8] see [RQ9]
        dec_long_word   <= (emit_words == WORDS_TWO) ? word_data : '0;  // see [RQ18]
        dec_cond_select <= emit_word[SEL_LSB +: 2];
        dec_words       <= emit_words;
        dec_cycles      <= emit_cycles;
        dec_jump_taken  <= emit_taken;
      end
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_magnitude_one_cycle: assert property (  // see [RQ5]
    accept && state_reg == ST_OPCODE && word_data == OPC_MAGNITUDE |=>
      dec_valid && dec_op == OP_MAGNITUDE_OF_ACCUMULATOR && dec_cycles == 3'h1 &&
      dec_words == 2'h1 && word_ready)
    else $error("magnitude opcode not decoded as one word one cycle");

  a_shifted_add_field: assert property (  // see [RQ6]
    accept && state_reg == ST_OPCODE && word_data[15:12] == 4'h2 |=>
      dec_valid && dec_op == OP_SUM_SHIFTED && dec_shift_count == $past(word_data[11:8]))
    else $error("shifted add decoded wrongly");

  a_long_add_waits: assert property (  // see [RQ7]
    accept && state_reg == ST_OPCODE && word_data[15:4] == 12'hbf9 |=>
      !dec_valid && state_reg == ST_OPERAND)
    else $error("long add did not wait for its constant");

  a_operand_not_opcode: assert property (  // see [RQ18]
    accept && state_reg == ST_OPERAND |=>
      dec_valid && dec_words == 2'h2 && dec_long_word == $past(word_data) &&
      dec_op == $past(pend_op_reg))
    else $error("second word was not taken as operand");

  a_carry_add_addr: assert property (  // see [RQ8]
    accept && state_reg == ST_OPCODE && word_data[15:8] == 8'h60 |=>
      dec_op == OP_SUM_WITH_CARRY && dec_short_field == $past(word_data[7:0]))
    else $error("add with carry decoded wrongly");

  a_jump_acc_stall: assert property (  // see [RQ12]
    accept && state_reg == ST_OPCODE && word_data == OPC_JUMP_ACC |=>
      dec_cycles == 3'h4 && !word_ready ##1 !word_ready ##1 !word_ready ##1 word_ready)
    else $error("jump to accumulator target did not take four cycles");

  a_loop_aux_cost: assert property (  // see [RQ13]
    dec_valid && dec_op == OP_LOOP_ON_AUX_NONZERO |->
      dec_cycles == (dec_jump_taken ? 3'h4 : 3'h2))
    else $error("loop on auxiliary nonzero has wrong cycle count");

  a_pin_low_cost: assert property (  // see [RQ15]
    dec_valid && dec_op == OP_CONDITIONAL_JUMP && dec_cond_select == 2'h0 |->
      dec_cycles == (dec_jump_taken ? 3'h4 : 3'h3))
    else $error("pin low jump has wrong cycle count");

  a_test_flag_jump: assert property (  // see [RQ14]
    accept && state_reg == ST_OPERAND && opcode_reg == 16'he100 |=>
      dec_jump_taken == $past(test_flag))
    else $error("test flag jump judged wrongly");

  a_sign_ge_jump: assert property (  // see [RQ16]
    accept && state_reg == ST_OPERAND && opcode_reg == {8'he3, COND_GE} |=>
      dec_jump_taken == $past(flags[3] | ~flags[2]))
    else $error("greater or equal jump judged wrongly");

  a_carry_jump: assert property (  // see [RQ17]
    accept && state_reg == ST_OPERAND && opcode_reg == {8'he3, COND_CARRY} |=>
      dec_jump_taken == $past(flags[0]) && dec_cycles == ($past(flags[0]) ? 3'h4 : 3'h2))
    else $error("carry jump judged wrongly");

  c_long_add: cover property (
    accept && state_reg == ST_OPCODE && word_data[15:4] == OPC_ADD_LONG ##1 accept);
  c_cond_taken: cover property (dec_valid && dec_op == OP_CONDITIONAL_JUMP && dec_jump_taken);
  c_cond_pin_not_taken: cover property (
    dec_valid && dec_op == OP_CONDITIONAL_JUMP && dec_cycles == 3'h3);
  c_jump_acc: cover property (dec_valid && dec_op == OP_JUMP_TO_ACCUMULATOR_TARGET);

endmodule : dsp_add_and_branch_decoder

`default_nettype wire

// *** hw/dsp_decode_pkg.sv ***
// Constants, field positions and types shared by the add and branch decoder.
`default_nettype none

package dsp_decode_pkg;

  localparam int WORD_W = 16;

  // Instruction word field positions.
  localparam int TOP_LSB   = 12;
  localparam int SHIFT_LSB = 8;
  localparam int SEL_LSB   = 8;
  localparam int STATE_LSB = 4;
  localparam int MASK_LSB  = 0;

  // Bit order inside a four-bit flag condition field, most significant first.
  localparam int FLAG_ZERO  = 3;
  localparam int FLAG_NEG   = 2;
  localparam int FLAG_OVF   = 1;
  localparam int FLAG_CARRY = 0;

  // Condition source selector codes.
  localparam logic [1:0] SRC_PIN_LOW    = 2'h0;
  localparam logic [1:0] SRC_TEST_SET   = 2'h1;
  localparam logic [1:0] SRC_TEST_CLEAR = 2'h2;
  localparam logic [1:0] SRC_NONE       = 2'h3;

  // Opcode patterns.
  localparam logic [3:0]  NIB_ADD_SHIFT   = 4'h2;
  localparam logic [3:0]  NIB_COND_JUMP   = 4'he;
  localparam logic [7:0]  PFX_ADD_HIGH    = 8'h61;
  localparam logic [7:0]  PFX_ADD_SHORT   = 8'hb8;
  localparam logic [7:0]  PFX_SUM_WITH_CARRY        = 8'h60;
  localparam logic [7:0]  PFX_SUM_WITHOUT_SIGN_EXTEND        = 8'h62;
  localparam logic [7:0]  PFX_SUM_SHIFTED_BY_TEMP        = 8'h63;
  localparam logic [7:0]  PFX_AUX_INC     = 8'h78;
  localparam logic [7:0]  PFX_AND_MEM     = 8'h6e;
  localparam logic [7:0]  PFX_LOOP_AUX    = 8'h7b;
  localparam logic [11:0] OPC_ADD_LONG    = 12'hbf9;
  localparam logic [11:0] OPC_AND_LONG    = 12'hbfb;
  localparam logic [15:0] OPC_MAGNITUDE   = 16'hbe00;
  localparam logic [15:0] OPC_AND_HIGH    = 16'hbe81;
  localparam logic [15:0] OPC_ACC_PRODUCT = 16'hbe04;
  localparam logic [15:0] OPC_JUMP_ACC    = 16'hbe20;
  localparam logic [15:0] OPC_JUMP_PIN    = 16'he000;

  // Flag condition bytes (state nibble, then mask nibble) of common branches.
  localparam logic [7:0] COND_GE       = 8'h8c;
  localparam logic [7:0] COND_GT       = 8'h04;
  localparam logic [7:0] COND_LE       = 8'hcc;
  localparam logic [7:0] COND_LT       = 8'h44;
  localparam logic [7:0] COND_CARRY    = 8'h11;
  localparam logic [7:0] COND_NO_CARRY = 8'h01;
  localparam logic [7:0] COND_NO_OVF   = 8'h02;

  // Word and cycle counts.
  localparam logic [1:0] WORDS_ONE   = 2'h1;
  localparam logic [1:0] WORDS_TWO   = 2'h2;
  localparam logic [2:0] CYC_ONE     = 3'h1;
  localparam logic [2:0] CYC_TWO     = 3'h2;
  localparam logic [2:0] CYC_THREE   = 3'h3;
  localparam logic [2:0] CYC_FOUR    = 3'h4;

  typedef enum logic [4:0] {
    OP_UNKNOWN                    = 5'h00,
    OP_MAGNITUDE_OF_ACCUMULATOR   = 5'h01,
    OP_SUM_SHIFTED                = 5'h02,
    OP_SUM_HIGH                   = 5'h03,
    OP_SUM_SHORT_IMM              = 5'h04,
    OP_SUM_LONG_IMM               = 5'h05,
    OP_SUM_WITH_CARRY             = 5'h06,
    OP_SUM_WITHOUT_SIGN_EXTEND    = 5'h07,
    OP_SUM_SHIFTED_BY_TEMP        = 5'h08,
    OP_AUX_REG_SHORT_INCREMENT    = 5'h09,
    OP_AND_MEM                    = 5'h0a,
    OP_AND_LONG_IMM               = 5'h0b,
    OP_AND_HIGH_IMM               = 5'h0c,
    OP_ACCUMULATE_PRODUCT         = 5'h0d,
    OP_JUMP_TO_ACCUMULATOR_TARGET = 5'h0e,
    OP_LOOP_ON_AUX_NONZERO        = 5'h0f,
    OP_CONDITIONAL_JUMP           = 5'h10
  } op_t;

  typedef enum logic [1:0] {
    ST_OPCODE  = 2'h0,
    ST_OPERAND = 2'h1,
    ST_STALL   = 2'h2
  } dec_state_t;

endpackage : dsp_decode_pkg

`default_nettype wire

// *** hw/flag_condition_eval.sv ***
// Condition evaluator for the conditional jump: source selector plus flag field.
`default_nettype none

module flag_condition_eval
  import dsp_decode_pkg::*;
(
  input  wire logic [1:0] cond_source_select,
  input  wire logic [3:0] flag_state,
  input  wire logic [3:0] flag_mask,
  input  wire logic [3:0] flags,
  input  wire logic       test_flag,
  input  wire logic       branch_input_pin,
  output logic            cond_met
);

  logic       source_ok;
  logic [3:0] flag_match;
  logic       flag_ok;

  always_comb begin
    unique case (cond_source_select)  // see [RQ1]
      SRC_PIN_LOW:    source_ok = ~branch_input_pin;
      SRC_TEST_SET:   source_ok = test_flag;
      SRC_TEST_CLEAR: source_ok = ~test_flag;
      SRC_NONE:       source_ok = 1'b1;
    endcase
  end

  // Flags arrive ordered zero, negative, overflow, carry from bit 3 down.
  assign flag_match = ~(flags ^ flag_state);  // see [RQ2]
  // An all-zero mask tests no flag, so the source selector alone decides.
  assign flag_ok = (flag_mask == 4'h0) | (|(flag_mask & flag_match));  // see [RQ3] see [RQ4]
  assign cond_met = source_ok & flag_ok;

endmodule : flag_condition_eval

`default_nettype wire

// *** dv/prog_word_source.sv ***
// Program memory model that hands instruction words to the decoder one by one.
`default_nettype none

module prog_word_source (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire logic        word_ready,
  output logic [15:0]      word_data,
  output logic             word_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] q[$];
  logic        will_take;
  logic        bubble;

  // Queue one word; the word after a two-word opcode is its operand.
  task automatic offer(input logic [15:0] w);
    q.push_back(w);
  endtask : offer

  // Judged at the falling edge, where ready has settled, so the take never races the edge.
  always @(negedge clk) begin
    will_take = word_valid && word_ready;
  end

  initial begin
    word_valid = 1'b0;
    word_data  = 16'h0000;
    will_take  = 1'b0;
    bubble     = 1'b0;
    forever begin
      @(posedge clk);
      #1;
      if (!rstn) begin
        word_valid = 1'b0;
      end else begin
        if (will_take) begin
          void'(q.pop_front());
          word_valid = 1'b0;
        end
        // An offered word is held until taken; an idle bus inverts its data on every idle cycle out of reset.
        if (!word_valid) begin
          if (q.size() > 0 && !(slow && !bubble)) begin
            bubble     = 1'b0;
            word_valid = 1'b1;
            word_data  = q[0];
          end else begin
            bubble    = slow && q.size() > 0;
            word_data = ~word_data;
          end
        end
      end
    end
  end
endmodule : prog_word_source

`default_nettype wire

// *** dv/dsp_add_and_branch_decoder_bench.sv ***
// Self-checking bench for the add, AND, product-accumulate and branch decoder.
`default_nettype none

module dsp_add_and_branch_decoder_bench
  import dsp_decode_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rstn;
  logic        slow_mode;
  logic [15:0] word_data;
  logic        word_valid;
  logic        word_ready;
  logic [3:0]  flags;
  logic        test_flag;
  logic        branch_input_pin;
  logic        aux_reg_nonzero;
  logic        dec_valid;
  op_t         dec_op;
  logic [3:0]  dec_shift_count;
  logic [7:0]  dec_short_field;
  logic [15:0] dec_long_word;
  logic [1:0]  dec_cond_select;
  logic [1:0]  dec_words;
  logic [2:0]  dec_cycles;
  logic        dec_jump_taken;
  int          failures;
  int          check_count;

  prog_word_source src_u (.clk(clk), .rstn(rstn), .slow(slow_mode), .word_ready(word_ready),
                          .word_data(word_data), .word_valid(word_valid));

  dsp_add_and_branch_decoder dut_u (
    .clk(clk), .rstn(rstn), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .flags(flags), .test_flag(test_flag),
    .branch_input_pin(branch_input_pin), .aux_reg_nonzero(aux_reg_nonzero),
    .dec_valid(dec_valid), .dec_op(dec_op), .dec_shift_count(dec_shift_count),
    .dec_short_field(dec_short_field), .dec_long_word(dec_long_word),
    .dec_cond_select(dec_cond_select), .dec_words(dec_words), .dec_cycles(dec_cycles),
    .dec_jump_taken(dec_jump_taken));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Worked out independently: source test, then masked flag comparison.
  function automatic logic exp_met(input logic [15:0] w, input logic [3:0] f,
                                   input logic t, input logic p);
    logic src;
    logic [3:0] m;
    m = w[3:0];
    case (w[9:8])
      2'h0: src = !p;
      2'h1: src = t;
      2'h2: src = !t;
      default: src = 1'b1;
    endcase
    return src && (m == 4'h0 || |(m & ~(f ^ w[7:4])));
  endfunction : exp_met

  // Issues one instruction, judges the answer, the refusal span and the lack of a second answer.
  task automatic run_instr(input logic [15:0] w0, input logic [15:0] w1, input bit two,
                           input op_t eop, input logic [2:0] ecyc, input logic etk,
                           input logic [1:0] sh_mode);
    int n;
    logic [15:0] eshift;
    n = 0;
    eshift = (sh_mode == 2'h2) ? 16'(w0[3:0]) : 16'(w0[11:8]);
    src_u.offer(w0);
    if (two) src_u.offer(w1);
    while (dec_valid !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_val("dec_valid", 16'h0001, 16'(dec_valid));
    check_val("dec_op", 16'(eop), 16'(dec_op));
    check_val("dec_words", two ? 16'h0002 : 16'h0001, 16'(dec_words));
    check_val("dec_cycles", 16'(ecyc), 16'(dec_cycles));
    check_val("dec_jump_taken", 16'(etk), 16'(dec_jump_taken));
    check_val("dec_long_word", two ? w1 : 16'h0000, dec_long_word);
    check_val("dec_short_field", 16'(w0[7:0]), 16'(dec_short_field));
    check_val("dec_cond_select", 16'(w0[9:8]), 16'(dec_cond_select));
    if (sh_mode != 2'h0) check_val("dec_shift_count", eshift, 16'(dec_shift_count));
    n = 0;
    while (word_ready !== 1'b1 && n < 8) begin
      n++;
      @(posedge clk);
      #1;
    end
    check_val("refused cycles", 16'(ecyc) - (two ? 16'h0002 : 16'h0001), 16'(n));
    @(posedge clk);
    #1;
    check_val("no second answer", 16'h0000, 16'(dec_valid));
    check_val("words left", 16'h0000, 16'(src_u.q.size()));
  endtask : run_instr

  task automatic test_reset;
    check_val("reset word_ready", 16'h0001, 16'(word_ready));
    check_val("reset dec_valid", 16'h0000, 16'(dec_valid));
    check_val("reset dec_op", 16'(OP_UNKNOWN), 16'(dec_op));
    $display("test reset done");
  endtask : test_reset

  task automatic test_one_word;
    logic [15:0] ops[12] = '{16'hbe00, 16'h2abc, 16'h6155, 16'hb8f0, 16'h6012, 16'h6234,
                             16'h6356, 16'h7807, 16'h6e99, 16'hbe04, 16'hbe20, 16'h0000};
    op_t eops[12] = '{OP_MAGNITUDE_OF_ACCUMULATOR, OP_SUM_SHIFTED, OP_SUM_HIGH,
                      OP_SUM_SHORT_IMM, OP_SUM_WITH_CARRY, OP_SUM_WITHOUT_SIGN_EXTEND,
                      OP_SUM_SHIFTED_BY_TEMP, OP_AUX_REG_SHORT_INCREMENT, OP_AND_MEM,
                      OP_ACCUMULATE_PRODUCT, OP_JUMP_TO_ACCUMULATOR_TARGET, OP_UNKNOWN};
    for (int i = 0; i < 12; i++) begin
      run_instr(ops[i], 16'h0000, 1'b0, eops[i], (i == 10) ? 3'h4 : 3'h1,
                (i == 10) ? 1'b1 : 1'b0, (i == 1) ? 2'h1 : 2'h0);
    end
    $display("test one word done");
  endtask : test_one_word

  task automatic test_two_word;
    run_instr(16'hbf93, 16'hbe20, 1'b1, OP_SUM_LONG_IMM, 3'h2, 1'b0, 2'h2);
    run_instr(16'hbfbc, 16'h00ff, 1'b1, OP_AND_LONG_IMM, 3'h2, 1'b0, 2'h2);
    run_instr(16'hbe81, 16'habcd, 1'b1, OP_AND_HIGH_IMM, 3'h2, 1'b0, 2'h0);
    $display("test two word done");
  endtask : test_two_word

  task automatic test_cond_jump;
    logic [15:0] codes[10] = '{16'he000, 16'he100, 16'he200, 16'he38c, 16'he304,
                               16'he3cc, 16'he344, 16'he311, 16'he301, 16'he302};
    logic [3:0] envs[4] = '{4'h0, 4'h5, 4'ha, 4'hc};
    logic tk;
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < 4; k++) begin
        flags = envs[k];
        test_flag = k[0];
        branch_input_pin = k[1];
        tk = exp_met(codes[i], envs[k], k[0], k[1]);
        run_instr(codes[i], 16'h1230 + 16'(k), 1'b1, OP_CONDITIONAL_JUMP,
                  tk ? 3'h4 : ((codes[i][9:8] == 2'h0) ? 3'h3 : 3'h2), tk, 2'h1);
      end
    end
    $display("test conditional jump done");
  endtask : test_cond_jump

  task automatic test_loop_and_slow;
    aux_reg_nonzero = 1'b1;
    run_instr(16'h7b42, 16'h0400, 1'b1, OP_LOOP_ON_AUX_NONZERO, 3'h4, 1'b1, 2'h0);
    aux_reg_nonzero = 1'b0;
    run_instr(16'h7b42, 16'h0401, 1'b1, OP_LOOP_ON_AUX_NONZERO, 3'h2, 1'b0, 2'h0);
    // A slow memory leaves one idle cycle between opcode and operand.
    slow_mode = 1'b1;
    flags = 4'h1;
    run_instr(16'he311, 16'h5a5a, 1'b1, OP_CONDITIONAL_JUMP, 3'h4, 1'b1, 2'h1);
    slow_mode = 1'b0;
    $display("test loop and slow memory done");
  endtask : test_loop_and_slow

  initial begin
    failures = 0;
    check_count = 0;
    rstn = 1'b0;
    slow_mode = 1'b0;
    flags = 4'h0;
    test_flag = 1'b0;
    branch_input_pin = 1'b1;
    aux_reg_nonzero = 1'b0;
    repeat (20) @(posedge clk);
    #1;
    test_reset();
    rstn = 1'b1;
    @(posedge clk);
    #1;
    test_one_word();
    test_two_word();
    test_cond_jump();
    test_loop_and_slow();
    complete_run();
  end

  // Whole run needs roughly 300 cycles; a hang is cut off well beyond that.
  initial begin
    #80000;
    failures++;
    complete_run();
  end
endmodule : dsp_add_and_branch_decoder_bench

`default_nettype wire
